// ===== logic/rgmc_regs.svh
// Register offsets, field positions, reset values and timing constants of the RF gain mode controller
// Contract
// RQ1: At reset a firmware check runs; operation starts only on a clean result.
// RQ2: After a clean boot the front indicator steps red, yellow, then green.
// RQ3: Any boot error lights the indicator steady red and raises a boot alarm.
// RQ4: A failed firmware check halts operation and blinks the indicator red.
// RQ5: Automatic group holds preset, set, set-equate; manual group holds manual, manual-equate.
// RQ6: Preset samples main-path power and steps the attenuator toward the stored target.
// RQ7: Set mode adjusts the offset in single 0.5 dB steps; other step sizes are refused.
// RQ8: A new set offset moves the loop target and is kept in nonvolatile storage.
// RQ9: Set-equate clears the stored offset to the preset point, then becomes set.
// RQ10: CW/video selection applies in preset or set only, never in manual.
// RQ11: In preset or set the controller toggles CW and video; the device applies it.
// RQ12: Video lowers the target by the chosen 2, 3, 4 or 5 dB offset.
// RQ13: A new unit starts in preset, video, with a 4 dB video offset.
// RQ14: Manual steps the level by 0.5 dB and then holds it without correction.
// RQ15: Entering manual restores the attenuator from the stored manual value.
// RQ16: Manual-equate stores the present attenuator as manual value, then becomes manual.
// RQ17: Later power-ups recall the stored settings and resume the last mode.
// RQ18: Attenuator is an unsigned 0.5 dB count that saturates at both ends.
// RQ19: An equate finishes its copy before switching; mode commands wait until then (the code refuses mode writes in the equate cycle instead).
`ifndef RGMC_REGS_SVH
`define RGMC_REGS_SVH
`define RGMC_AW        8
`define RGMC_A_MODE    8'h00
`define RGMC_A_SEC     8'h04
`define RGMC_A_STEP    8'h08
`define RGMC_A_ATTEN   8'h0c
`define RGMC_A_STATUS  8'h10
`define RGMC_A_ISTAT   8'h14
`define RGMC_A_IMASK   8'h18
`define RGMC_A_TARGET  8'h1c
`define RGMC_SEC_VIDEO 0
`define RGMC_STEP_UP   8'h01
`define RGMC_STEP_DN   8'hff
`define RGMC_OFF_MAX   8'sh7f
`define RGMC_OFF_MIN   8'sh81
`define RGMC_ATT_MIN   8'h00
`define RGMC_ATT_MAX   8'hff
`define RGMC_ATT_RST   8'h40
`define RGMC_TGT_RST   8'h80
`define RGMC_VSEL_RST  2'h2
`define RGMC_VID_BASE  3'h2
`define RGMC_EV_BOOT   0
`define RGMC_EV_REJ    1
`define RGMC_EV_MODE   2
`define RGMC_NEV       3
`define RGMC_FW_AW     4
`define RGMC_FW_LAST   4'hf
`define RGMC_CRC_POLY  16'h1021
`define RGMC_CRC_INIT  16'hffff
`define RGMC_CLK_MHZ   100
`define RGMC_PHASE_MS  500
`define RGMC_BLINK_MS  250
`define RGMC_AGC_US    10
`endif

// ===== logic/rgmc_pkg.sv
// Types shared by the RF gain mode controller
`include "rgmc_regs.svh"
package rgmc_pkg;
  typedef enum logic [2:0] {
    MD_PRESET = 3'b000,
    MD_SET    = 3'b001,
    MD_SETEQ  = 3'b010,
    MD_MANUAL = 3'b011,
    MD_MANEQ  = 3'b100
  } rgmc_mode_t;
  typedef enum logic [2:0] {
    BT_CRC = 3'b000,
    BT_RED = 3'b001,
    BT_YEL = 3'b010,
    BT_GRN = 3'b011,
    BT_ERR = 3'b100,
    BT_BAD = 3'b101
  } rgmc_boot_t;
  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [`RGMC_AW-1:0] paddr;
    logic [31:0]         pwdata;
  } rgmc_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rgmc_apb_rsp_t;
  typedef struct packed {
    logic red;
    logic green;
  } rgmc_led_t;
endpackage

// ===== logic/rgmc_boot_crc.sv
// Boot-time firmware walker and CRC check
`timescale 1ns/1ps
`include "rgmc_regs.svh"
module rgmc_boot_crc (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [15:0]           fw_rdata,
  output logic      [`RGMC_FW_AW-1:0] fw_addr,
  output logic                       done,
  output logic                       pass
);
  logic [`RGMC_FW_AW-1:0] addr_q;
  logic [`RGMC_FW_AW-1:0] got_q;
  logic                   vld_q;
  logic                   done_q;
  logic                   pass_q;
  logic [15:0]            crc_q;

  // Bitwise CRC-16 over one image word, msb first
  function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ `RGMC_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // Image read has one cycle latency; last word holds the expected check value
  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_q <= '0;
      got_q  <= '0;
      vld_q  <= 1'b0;
      done_q <= 1'b0;
      pass_q <= 1'b0;
      crc_q  <= `RGMC_CRC_INIT;
    end else if (!done_q) begin
      if (addr_q != `RGMC_FW_LAST) begin
        addr_q <= addr_q + 1'b1;
      end
      vld_q <= 1'b1;
      got_q <= addr_q;
      if (vld_q) begin
        if (got_q == `RGMC_FW_LAST) begin
          done_q <= 1'b1;
          pass_q <= (fw_rdata == crc_q); // see RQ1
        end else begin
          crc_q <= crc16_step(crc_q, fw_rdata);
        end
      end
    end
  end

  assign fw_addr = addr_q;
  assign done    = done_q;
  assign pass    = pass_q;
endmodule

// ===== logic/rgmc_top.sv
// RF gain mode controller: boot check, gain modes, settings store and APB registers
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "rgmc_regs.svh"
module rgmc_top #(
  parameter int PHASE_CYC = `RGMC_PHASE_MS * 1000 * `RGMC_CLK_MHZ,
  parameter int BLINK_CYC = `RGMC_BLINK_MS * 1000 * `RGMC_CLK_MHZ
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    por,
  input  wire rgmc_pkg::rgmc_apb_req_t apb_req,
  output rgmc_pkg::rgmc_apb_rsp_t      apb_rsp,
  output logic                         irq,
  input  wire logic [7:0]              rf_power,
  output logic      [7:0]              atten,
  input  wire logic [15:0]             fw_rdata,
  input  wire logic                    fw_err,
  output logic      [`RGMC_FW_AW-1:0]  fw_addr,
  output rgmc_pkg::rgmc_led_t          front_status_indicator,
  output logic                         boot_alarm,
  output logic                         running
);
  import rgmc_pkg::*;

  localparam int AGC_CYC = `RGMC_AGC_US * `RGMC_CLK_MHZ;

  rgmc_boot_t           boot_q;
  rgmc_mode_t           mode_q;
  rgmc_mode_t           new_mode;
  rgmc_apb_rsp_t        rsp_q;
  rgmc_led_t            led_q;
  logic [25:0]          ph_cnt_q;
  logic                 blink_q;
  logic                 running_q;
  logic                 alarm_q;
  logic                 crc_done;
  logic                 crc_pass;
  logic [7:0]           pw_s1_q;
  logic [7:0]           pw_s2_q;
  logic                 video_q;
  logic [1:0]           vsel_q;
  logic signed [7:0]    nvm_off_q;
  logic [7:0]           nvm_man_q;
  logic [7:0]           nvm_tgt_q;
  logic [7:0]           atten_q;
  logic [9:0]           agc_cnt_q;
  logic                 man_seen_q;
  logic [`RGMC_NEV-1:0] stat_q;
  logic [`RGMC_NEV-1:0] mask_q;
  logic                 irq_q;
  logic [31:0]          rd_data;
  logic                 rd_hit;
  logic signed [9:0]    tgt;
  logic                 wr_fire;
  logic                 wr_mode;
  logic                 wr_sec;
  logic                 wr_step;
  logic                 busy;
  logic                 mode_ok;
  logic                 step_up;
  logic                 step_dn;
  logic                 step_ok;
  logic                 sec_ok;
  logic                 reject;
  logic                 man_enter;
  logic                 agc_on;
  logic                 agc_tick;
  logic                 pw_gt;
  logic                 pw_lt;
  logic                 boot_fail;
  logic [`RGMC_NEV-1:0] ev;

  // Saturating one-count step of the attenuator
  function automatic logic [7:0] sat_step(input logic [7:0] v, input logic up, input logic dn);
    if (up && v != `RGMC_ATT_MAX) begin
      return v + 8'h01;
    end
    if (dn && v != `RGMC_ATT_MIN) begin
      return v - 8'h01;
    end
    return v;
  endfunction

  // Video offset select 0..3 maps to 2..5 dB, counted in half-dB units
  function automatic logic [7:0] vid_cnt(input logic [1:0] sel);
    return {4'h0, ({1'b0, sel} + `RGMC_VID_BASE), 1'b0};
  endfunction

  rgmc_boot_crc u_crc (
    .mclk     (mclk),
    .rst      (rst),
    .fw_rdata (fw_rdata),
    .fw_addr  (fw_addr),
    .done     (crc_done),
    .pass     (crc_pass)
  );

  // Power reading comes from the converter pins, so it is synchronised first
  always_ff @(posedge mclk) begin
    pw_s1_q <= rf_power;
    pw_s2_q <= pw_s1_q;
  end

  // Boot sequence: check, then red, yellow, green; errors park the machine
  always_ff @(posedge mclk) begin
    if (rst) begin
      boot_q    <= BT_CRC;
      ph_cnt_q  <= '0;
      blink_q   <= 1'b0;
      running_q <= 1'b0;
    end else begin
      case (boot_q)
        BT_CRC: begin
          if (fw_err) begin
            boot_q <= BT_ERR; // see RQ3
          end else if (crc_done) begin
            boot_q <= crc_pass ? BT_RED : BT_BAD; // see RQ1
          end
        end
        BT_RED, BT_YEL: begin
          if (ph_cnt_q == 26'(PHASE_CYC - 1)) begin
            ph_cnt_q <= '0;
            boot_q   <= (boot_q == BT_RED) ? BT_YEL : BT_GRN; // see RQ2
            if (boot_q == BT_YEL) begin
              running_q <= 1'b1; // see RQ1
            end
          end else begin
            ph_cnt_q <= ph_cnt_q + 26'h1;
          end
        end
        BT_BAD: begin
          if (ph_cnt_q == 26'(BLINK_CYC - 1)) begin
            ph_cnt_q <= '0;
            blink_q  <= !blink_q; // see RQ4
          end else begin
            ph_cnt_q <= ph_cnt_q + 26'h1;
          end
        end
        default: ;
      endcase
    end
  end

  assign boot_fail = (boot_q == BT_CRC) && (fw_err || (crc_done && !crc_pass));

  // Indicator colours; yellow is red and green together
  always_ff @(posedge mclk) begin
    if (rst) begin
      led_q   <= '0;
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= boot_fail; // see RQ3
      case (boot_q)
        BT_RED:  led_q <= '{red: 1'b1, green: 1'b0}; // see RQ2
        BT_YEL:  led_q <= '{red: 1'b1, green: 1'b1};
        BT_GRN:  led_q <= '{red: 1'b0, green: 1'b1};
        BT_ERR:  led_q <= '{red: 1'b1, green: 1'b0}; // see RQ3
        BT_BAD:  led_q <= '{red: blink_q, green: 1'b0}; // see RQ4
        default: led_q <= '0;
      endcase
    end
  end

  // Command decode; writes take effect on the edge that completes the access
  assign wr_fire  = apb_req.psel && apb_req.penable && apb_req.pwrite && rsp_q.pready;
  assign wr_mode  = wr_fire && (apb_req.paddr == `RGMC_A_MODE);
  assign wr_sec   = wr_fire && (apb_req.paddr == `RGMC_A_SEC);
  assign wr_step  = wr_fire && (apb_req.paddr == `RGMC_A_STEP);
  assign new_mode = rgmc_mode_t'(apb_req.pwdata[2:0]);
  assign busy     = (mode_q == MD_SETEQ) || (mode_q == MD_MANEQ);
  assign mode_ok  = wr_mode && running_q && !busy && (apb_req.pwdata[2:0] <= MD_MANEQ); // see RQ5, RQ19
  assign step_up  = (apb_req.pwdata[7:0] == `RGMC_STEP_UP);
  assign step_dn  = (apb_req.pwdata[7:0] == `RGMC_STEP_DN);
  assign step_ok  = wr_step && running_q && !man_enter && (step_up || step_dn)
                    && ((mode_q == MD_SET) || (mode_q == MD_MANUAL)); // see RQ7, RQ14
  assign sec_ok   = wr_sec && running_q && ((mode_q == MD_PRESET) || (mode_q == MD_SET)); // see RQ10, RQ11
  assign reject   = (wr_mode && !mode_ok) || (wr_step && !step_ok) || (wr_sec && !sec_ok);

  // Operating mode lives in the settings store: rst leaves it, power-on loads defaults
  always_ff @(posedge mclk) begin
    if (por) begin
      mode_q <= MD_PRESET; // see RQ13
    end else if (mode_q == MD_SETEQ) begin
      mode_q <= MD_SET; // see RQ9
    end else if (mode_q == MD_MANEQ) begin
      mode_q <= MD_MANUAL; // see RQ16
    end else if (mode_ok) begin
      mode_q <= new_mode; // see RQ17
    end
  end

  // Secondary CW/video selection, stored
  always_ff @(posedge mclk) begin
    if (por) begin
      video_q <= 1'b1; // see RQ13
      vsel_q  <= `RGMC_VSEL_RST;
    end else if (sec_ok) begin
      video_q <= apb_req.pwdata[`RGMC_SEC_VIDEO]; // see RQ11
      vsel_q  <= apb_req.pwdata[2:1]; // see RQ12
    end
  end

  // Stored set offset; the equate copy happens in the equate cycle itself
  always_ff @(posedge mclk) begin
    if (por) begin
      nvm_off_q <= '0;
    end else if (mode_q == MD_SETEQ) begin
      nvm_off_q <= '0; // see RQ9, RQ19
    end else if (step_ok && mode_q == MD_SET) begin
      if (step_up && nvm_off_q != `RGMC_OFF_MAX) begin
        nvm_off_q <= nvm_off_q + 8'sh01; // see RQ7, RQ8
      end else if (step_dn && nvm_off_q != `RGMC_OFF_MIN) begin
        nvm_off_q <= nvm_off_q - 8'sh01;
      end
    end
  end

  // Stored manual attenuator value and factory target
  always_ff @(posedge mclk) begin
    if (por) begin
      nvm_man_q <= `RGMC_ATT_RST;
      nvm_tgt_q <= `RGMC_TGT_RST;
    end else begin
      if (mode_q == MD_MANEQ) begin
        nvm_man_q <= atten_q; // see RQ16, RQ19
      end else if (step_ok && mode_q == MD_MANUAL) begin
        nvm_man_q <= sat_step(atten_q, step_up, step_dn); // see RQ14
      end
      if (wr_fire && apb_req.paddr == `RGMC_A_TARGET) begin
        nvm_tgt_q <= apb_req.pwdata[7:0];
      end
    end
  end

  // Loop target in half-dB units: preset, plus set offset, minus video offset
  always_comb begin
    tgt = signed'({2'b00, nvm_tgt_q});
    if (mode_q == MD_SET) begin
      tgt = tgt + 10'(nvm_off_q); // see RQ8
    end
    if (video_q) begin
      tgt = tgt - signed'({2'b00, vid_cnt(vsel_q)}); // see RQ12
    end
  end

  assign pw_gt     = signed'({2'b00, pw_s2_q}) > tgt;
  assign pw_lt     = signed'({2'b00, pw_s2_q}) < tgt;
  assign agc_on    = running_q && ((mode_q == MD_PRESET) || (mode_q == MD_SET));
  assign agc_tick  = (agc_cnt_q == 10'(AGC_CYC - 1));
  assign man_enter = running_q && (mode_q == MD_MANUAL) && !man_seen_q;

  // Attenuator: recall on manual entry, manual steps, else periodic loop correction
  always_ff @(posedge mclk) begin
    if (rst) begin
      atten_q    <= `RGMC_ATT_MAX;
      agc_cnt_q  <= '0;
      man_seen_q <= 1'b0;
    end else begin
      man_seen_q <= running_q && (mode_q == MD_MANUAL);
      agc_cnt_q  <= agc_tick ? 10'h000 : agc_cnt_q + 10'h001;
      if (man_enter) begin
        atten_q <= nvm_man_q; // see RQ15, RQ17
      end else if (step_ok && mode_q == MD_MANUAL) begin
        atten_q <= sat_step(atten_q, step_up, step_dn); // see RQ14, RQ18
      end else if (agc_on && agc_tick) begin
        atten_q <= sat_step(atten_q, pw_gt, pw_lt); // see RQ6, RQ18
      end
    end
  end

  // Sticky events; a new event wins over a same-cycle clear
  assign ev = {mode_ok, reject, boot_fail};
  always_ff @(posedge mclk) begin
    if (rst) begin
      stat_q <= '0;
      mask_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
      if (wr_fire && apb_req.paddr == `RGMC_A_ISTAT) begin
        stat_q <= (stat_q & ~apb_req.pwdata[`RGMC_NEV-1:0]) | ev;
      end else begin
        stat_q <= stat_q | ev;
      end
      if (wr_fire && apb_req.paddr == `RGMC_A_IMASK) begin
        mask_q <= apb_req.pwdata[`RGMC_NEV-1:0];
      end
    end
  end

  // Read mux; unmapped offsets read zero and flag an error
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (apb_req.paddr)
      `RGMC_A_MODE:   rd_data = {29'h0, mode_q};
      `RGMC_A_SEC:    rd_data = {29'h0, vsel_q, video_q};
      `RGMC_A_STEP:   rd_data = {24'h0, nvm_off_q};
      `RGMC_A_ATTEN:  rd_data = {16'h0, nvm_man_q, atten_q};
      `RGMC_A_STATUS: rd_data = {26'h0, running_q, led_q, boot_q};
      `RGMC_A_ISTAT:  rd_data = {29'h0, stat_q};
      `RGMC_A_IMASK:  rd_data = {29'h0, mask_q};
      `RGMC_A_TARGET: rd_data = {24'h0, nvm_tgt_q};
      default:        rd_hit  = 1'b0;
    endcase
  end

  // APB slave: one wait state, answer registered
  always_ff @(posedge mclk) begin
    if (rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q.pready <= apb_req.psel && apb_req.penable && !rsp_q.pready;
      if (apb_req.psel && apb_req.penable && !rsp_q.pready) begin
        rsp_q.prdata  <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
        rsp_q.pslverr <= !rd_hit;
      end
    end
  end

  assign apb_rsp                = rsp_q;
  assign irq                    = irq_q;
  assign atten                  = atten_q;
  assign front_status_indicator = led_q;
  assign boot_alarm             = alarm_q;
  assign running                = running_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || por);

  sequence s_seteq;
    mode_q == MD_SETEQ;
  endsequence

  sequence s_maneq;
    mode_q == MD_MANEQ;
  endsequence

  a_run_gate: assert property ($rose(running_q) |-> crc_done && crc_pass) // see RQ1
    else $error("running without a clean firmware check");
  a_led_order: assert property (($changed(boot_q) && boot_q inside {BT_YEL, BT_GRN})
    |-> $past(boot_q) == ((boot_q == BT_YEL) ? BT_RED : BT_YEL)) // see RQ2
    else $error("indicator sequence out of order");
  a_err_red: assert property ((boot_q == BT_CRC && fw_err) |=> (alarm_q && boot_q == BT_ERR) // see RQ3
    ##1 (led_q.red && !led_q.green && !alarm_q)[*3])
    else $error("boot error not steady red with one alarm");
  a_bad_halt: assert property (boot_q == BT_BAD |-> !running_q && !led_q.green) // see RQ4
    else $error("failed check did not halt");
  a_set_step: assert property ((step_ok && mode_q == MD_SET && step_up && nvm_off_q != `RGMC_OFF_MAX)
    |=> nvm_off_q == $past(nvm_off_q) + 8'sh01) // see RQ7
    else $error("set step not one half-dB count");
  a_seteq_seq: assert property (s_seteq |=> mode_q == MD_SET && nvm_off_q == 8'sh00) // see RQ9
    else $error("set-equate did not copy and switch");
  a_sec_manual: assert property ((wr_sec && mode_q == MD_MANUAL) |=> $stable(video_q) && $stable(vsel_q)) // see RQ10
    else $error("secondary changed in manual");
  a_manual_hold: assert property ((mode_q == MD_MANUAL && !step_ok && !man_enter) |=> $stable(atten_q)) // see RQ14
    else $error("attenuator moved in manual");
  a_man_recall: assert property (man_enter |=> atten_q == $past(nvm_man_q)) // see RQ15
    else $error("manual entry did not recall stored value");
  a_maneq_copy: assert property (s_maneq |=> mode_q == MD_MANUAL && nvm_man_q == $past(atten_q)) // see RQ16
    else $error("manual-equate did not copy and switch");
  a_atten_sat: assert property ((atten_q == `RGMC_ATT_MAX && agc_on && agc_tick && pw_gt)
    |=> atten_q == `RGMC_ATT_MAX) // see RQ18
    else $error("attenuator wrapped past maximum");
endmodule

// ===== testbench/rgmc_fw_model.sv
// Firmware image store seen by the boot walker, with its check word
`timescale 1ns/1ps
`include "rgmc_regs.svh"
module rgmc_fw_model (
  input  wire logic                   mclk,
  input  wire logic                   corrupt,
  input  wire logic [`RGMC_FW_AW-1:0] fw_addr,
  output logic      [15:0]            fw_rdata
);
  // Image words are arbitrary; only the check word has to agree with them
  function automatic logic [15:0] word_at(input int i);
    return 16'h3c5a ^ (16'(i) << 4);
  endfunction
  // Check word over words 0..14, msb first
  function automatic logic [15:0] image_crc();
    logic [15:0] c;
    logic [15:0] w;
    c = `RGMC_CRC_INIT;
    for (int i = 0; i < 15; i++) begin
      w = word_at(i);
      for (int b = 15; b >= 0; b--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? `RGMC_CRC_POLY : 16'h0000);
      end
    end
    return c;
  endfunction
  // One-cycle latency like a sync ROM; corrupt flips a check bit to force a failed check
  always_ff @(posedge mclk) begin
    fw_rdata <= (fw_addr == `RGMC_FW_LAST) ? image_crc() ^ {15'h0000, corrupt} : word_at(int'(fw_addr));
  end
endmodule

// ===== testbench/rf_gain_mode_controller_tb.sv
// Self-checking bench for the RF gain mode controller
`timescale 1ns/1ps
`include "rgmc_regs.svh"
`define chk(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module rf_gain_mode_controller_tb;
  import rgmc_pkg::*;
  logic                   mclk;
  logic                   rst;
  logic                   por;
  logic                   corrupt;
  logic                   fw_err;
  rgmc_apb_req_t          req;
  rgmc_apb_rsp_t          rsp;
  logic                   irq;
  logic [7:0]             rf_power;
  logic [7:0]             atten;
  logic [15:0]            fw_rdata;
  logic [`RGMC_FW_AW-1:0] fw_addr;
  rgmc_led_t              led;
  logic                   boot_alarm;
  logic                   running;
  logic [31:0]            rdat;
  logic                   rerr;
  logic [1:0]             last;
  logic [1:0]             hist[$];
  int                     alarm_cnt;
  int                     err_count;
  int                     tests_run;
  int                     cyc;
  // Short indicator phases keep the boot sequence to a few dozen cycles
  rgmc_top #(.PHASE_CYC(4), .BLINK_CYC(2)) dut_u (
    .mclk(mclk), .rst(rst), .por(por), .apb_req(req), .apb_rsp(rsp), .irq(irq), .rf_power(rf_power),
    .atten(atten), .fw_rdata(fw_rdata), .fw_err(fw_err), .fw_addr(fw_addr), .front_status_indicator(led),
    .boot_alarm(boot_alarm), .running(running));
  rgmc_fw_model fw_u (.mclk(mclk), .corrupt(corrupt), .fw_addr(fw_addr), .fw_rdata(fw_rdata));
  always #5 mclk = ~mclk;
  // Indicator history and alarm pulses, sampled mid-cycle where outputs are settled
  always @(negedge mclk) begin
    if (boot_alarm === 1'b1) alarm_cnt++;
    if (2'(led) !== last) begin
      hist.push_back(2'(led));
      last = 2'(led);
    end
  end
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    n = 0;
    // Answer is taken at the rising edge that samples pready high
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 64);
    if (n == 64) err_count++;
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    @(posedge mclk);
    req <= '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `chk(rdat & m, e)
  endtask
  // A refused command leaves its mark in status bit 1, which is then cleared
  task automatic refused();
    rd_chk(`RGMC_A_ISTAT, 32'h2, 32'h2);
    apb(1'b1, `RGMC_A_ISTAT, 32'h2);
  endtask
  // Reset (with or without factory restore) and wait for green or a boot alarm
  task automatic boot(input logic p, input logic c, input logic e);
    int n;
    por <= p;
    rst <= 1'b1;
    corrupt <= c;
    fw_err <= e;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    por <= 1'b0;
    hist.delete();
    last = 2'b00;
    alarm_cnt = 0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (running !== 1'b1 && alarm_cnt == 0 && n < 200);
    if (n == 200) err_count++;
    // Indicator lags the boot state by a cycle, so let green reach the history
    repeat (2) @(posedge mclk);
    fw_err <= 1'b0;
  endtask
  initial begin
    mclk = 1'b0;
    req = '0;
    rf_power = 8'h78;
    corrupt = 1'b0;
    fw_err = 1'b0;
    rst = 1'b1;
    por = 1'b1;
    boot(1'b1, 1'b0, 1'b0);
    `chk({hist.size() == 3, hist[0], hist[1], hist[2]}, 7'b1_10_11_01)
    `chk(fw_addr, 4'hf)
    rd_chk(`RGMC_A_STATUS, 32'h3f, 32'h2b);
    rd_chk(`RGMC_A_MODE, 32'h7, 32'h0);
    rd_chk(`RGMC_A_SEC, 32'h7, 32'h5);
    // Power below target (0x78 with 4 dB video) pulls the attenuator down one count a tick
    rf_power <= 8'h00;
    repeat (2500) @(posedge mclk);
    `chk(atten < 8'hff && atten > 8'hfb, 1'b1)
    rf_power <= 8'hff;
    repeat (5000) @(posedge mclk);
    `chk(atten, 8'hff)
    rf_power <= 8'h78;
    apb(1'b1, `RGMC_A_IMASK, 32'h2);
    apb(1'b1, `RGMC_A_STEP, 32'h1);
    repeat (3) @(negedge mclk);
    `chk(irq, 1'b1)
    apb(1'b1, `RGMC_A_ISTAT, 32'h7);
    repeat (3) @(negedge mclk);
    `chk(irq, 1'b0)
    apb(1'b1, `RGMC_A_MODE, 32'h1);
    apb(1'b1, `RGMC_A_STEP, 32'h1);
    apb(1'b1, `RGMC_A_STEP, 32'h1);
    apb(1'b1, `RGMC_A_STEP, 32'hff);
    rd_chk(`RGMC_A_STEP, 32'hff, 32'h1);
    apb(1'b1, `RGMC_A_STEP, 32'h2);
    refused();
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, `RGMC_A_SEC, 32'(2 * s + 1));
      rd_chk(`RGMC_A_SEC, 32'h7, 32'(2 * s + 1));
    end
    apb(1'b1, `RGMC_A_SEC, 32'h4);
    rd_chk(`RGMC_A_SEC, 32'h7, 32'h4);
    apb(1'b1, `RGMC_A_SEC, 32'h5);
    apb(1'b1, `RGMC_A_MODE, 32'h2);
    rd_chk(`RGMC_A_MODE, 32'h7, 32'h1);
    rd_chk(`RGMC_A_STEP, 32'hff, 32'h0);
    apb(1'b1, `RGMC_A_MODE, 32'h3);
    repeat (3) @(negedge mclk);
    `chk(atten, 8'h40)
    apb(1'b1, `RGMC_A_STEP, 32'h1);
    rd_chk(`RGMC_A_ATTEN, 32'hffff, 32'h4141);
    // No correction in manual even with power far off target
    rf_power <= 8'h00;
    repeat (3000) @(posedge mclk);
    `chk(atten, 8'h41)
    rf_power <= 8'h78;
    apb(1'b1, `RGMC_A_SEC, 32'h1);
    refused();
    rd_chk(`RGMC_A_SEC, 32'h7, 32'h5);
    apb(1'b1, `RGMC_A_MODE, 32'h4);
    rd_chk(`RGMC_A_MODE, 32'h7, 32'h3);
    rd_chk(`RGMC_A_ATTEN, 32'hff00, 32'h4100);
    apb(1'b0, 8'h20, 32'h0);
    `chk({rerr, rdat}, {1'b1, 32'h0})
    boot(1'b0, 1'b0, 1'b0);
    rd_chk(`RGMC_A_MODE, 32'h7, 32'h3);
    repeat (3) @(negedge mclk);
    `chk(atten, 8'h41)
    boot(1'b0, 1'b1, 1'b0);
    repeat (16) @(negedge mclk);
    `chk({alarm_cnt == 1, hist.size() > 2, hist[0], hist[1], running}, 7'b1_1_10_00_0)
    rd_chk(`RGMC_A_STATUS, 32'h7, 32'h5);
    rd_chk(`RGMC_A_ISTAT, 32'h1, 32'h1);
    boot(1'b0, 1'b0, 1'b1);
    repeat (16) @(negedge mclk);
    `chk({alarm_cnt == 1, hist.size() == 1, hist[0], running}, 5'b1_1_10_0)
    rd_chk(`RGMC_A_STATUS, 32'h7, 32'h4);
    wrap_up();
  end
endmodule
